// file: verilog/pbc_top.v
// Local design decisions: the placing of the registers and the AXI4-Lite slave port.
`timescale 1ns/1ps
`default_nettype none
`include "pbc_consts.vh"
// Overview of operation
// [R1] off and high-impedance press held 32 ms: start enabling outputs
// [R2] go active only when in regulation and held past selected hold time
// [R3] release before hold time during power on: outputs off, back to off
// [R4] fault during power on before release: outputs off, back to off
// [R5] button may stay held in power on; active entered only after release
// [R6] high-impedance press over 4 s: on release off 0.5 s, start 0.5 s
// [R7] high-impedance power cycle only when its enable is set, needs 4 s
// [R8] high-impedance press reaching 6 s with enable: off at once
// [R9] power off only when its enable is set, never under 6 s
// [R10] after power off outputs stay off until a fresh power-on press
// [R11] low-impedance press 32 ms to 4 s: reset low at 32 ms until release
// [R12] low-impedance press over 4 s: power cycle on release, no enable
// [R13] both enables: 4 to 6 s gives power cycle, over 6 s power off
// [R14] enables are factory straps, read only; both clear disables both
// [R15] pins one and two: any function but led; in, open drain, push-pull
// [R16] pins three and four: any function with led; input or open drain
// [R17] button low drives interrupt low; status bit and counter readable
// [R18] button and impedance synchronised; durations counted in ms
module pbc_top #(
	parameter TICK_CYCLES = `PBC_TICK_NS / `PBC_CLK_PERIOD_NS
) (
	// clocking
	input  wire        clock,
	input  wire        rst,
	input  wire        clock_enable,
	// pushbutton and power path
	input  wire        button_press_n,
	input  wire        low_impedance,
	input  wire        all_in_regulation,
	input  wire        fault_detected,
	input  wire [1:0]  factory_config,
	output reg         regulator_enable,
	output reg         system_reset_n,
	output reg         interrupt_request_n,
	output reg         voltage_scaling_select,
	output reg         external_good_input,
	// multi-purpose pins
	input  wire [3:0]  multi_pin_in,
	output reg  [3:0]  multi_pin_out,
	output reg  [3:0]  multi_pin_oe,
	// axi4-lite slave
	input  wire [31:0] s_axi_awaddr,
	input  wire        s_axi_awvalid,
	output reg         s_axi_awready,
	input  wire [31:0] s_axi_wdata,
	input  wire [3:0]  s_axi_wstrb,
	input  wire        s_axi_wvalid,
	output reg         s_axi_wready,
	output reg  [1:0]  s_axi_bresp,
	output reg         s_axi_bvalid,
	input  wire        s_axi_bready,
	input  wire [31:0] s_axi_araddr,
	input  wire        s_axi_arvalid,
	output reg         s_axi_arready,
	output reg  [31:0] s_axi_rdata,
	output reg  [1:0]  s_axi_rresp,
	output reg         s_axi_rvalid,
	input  wire        s_axi_rready
);
	localparam [4:0] S_OFF   = 5'h01;
	localparam [4:0] S_START = 5'h02;
	localparam [4:0] S_ACT   = 5'h04;
	localparam [4:0] S_COFF  = 5'h08;
	localparam [4:0] S_CST   = 5'h10;
	localparam [31:0] TICK_SPAN = TICK_CYCLES - 1;
	localparam [`PBC_DIV_W-1:0] TICK_LAST = TICK_SPAN[`PBC_DIV_W-1:0];
	wire [5:0]            sync_lv;
	wire                  btn_low, lowimp_s, release_ev, powered;
	wire [3:0]            pin_s, next_pin_out, next_pin_oe;
	wire [3:0]            good_hit, vsel_hit;
	wire [31:0]           w_mask;
	wire [`PBC_MS_W-1:0]  hold_ms;
	reg  [`PBC_DIV_W-1:0] tick_div;
	reg                   tick, btn_low_q, imp_low, rd_hit;
	reg                   armed, next_armed, soft_rst, next_soft_rst;
	reg                   cycle_en, shut_en, aw_full, w_full;
	reg  [`PBC_MS_W-1:0]  press_ms, last_ms, phase_ms;
	reg  [4:0]            state, next_state;
	reg  [31:0]           ctrl, pincfg, aw_addr, w_data, rd_word;
	reg  [3:0]            w_strb;

	pbc_sync #(
		.WIDTH(6)
	) u_sync (
		.clock       (clock),
		.rst         (rst),
		.clock_enable(clock_enable),
		.async_in    ({button_press_n, low_impedance, multi_pin_in}),
		.sync_out    (sync_lv)
	); // R18

	assign btn_low    = ~sync_lv[5];
	assign lowimp_s   = sync_lv[4];
	assign pin_s      = sync_lv[3:0];
	assign release_ev = ~btn_low & btn_low_q;
	assign powered    = |(state & (S_START | S_ACT | S_CST));

	// ms timebase and press timing
	always @(posedge clock)
	begin
		if (rst)
		begin
			tick_div  <= {`PBC_DIV_W{1'b0}};
			tick      <= 1'b0;
			btn_low_q <= 1'b0;
			imp_low   <= 1'b0;
			press_ms  <= {`PBC_MS_W{1'b0}};
			last_ms   <= {`PBC_MS_W{1'b0}};
			phase_ms  <= {`PBC_MS_W{1'b0}};
		end
		else if (clock_enable)
		begin
			tick <= (tick_div == TICK_LAST);
			if (tick_div == TICK_LAST)
				tick_div <= {`PBC_DIV_W{1'b0}};
			else
				tick_div <= tick_div + 1'b1;
			btn_low_q <= btn_low;
			// class is fixed at the start of a press so a bouncing
			// impedance line cannot change the function mid-press
			if (btn_low & ~btn_low_q)
				imp_low <= lowimp_s;
			if (!btn_low)
				press_ms <= {`PBC_MS_W{1'b0}};
			else if (tick && press_ms != `PBC_MS_MAX)
				press_ms <= press_ms + 1'b1; // R18
			if (release_ev)
				last_ms <= press_ms;
			if (state != next_state)
				phase_ms <= {`PBC_MS_W{1'b0}};
			else if (tick && phase_ms != `PBC_MS_MAX)
				phase_ms <= phase_ms + 1'b1;
		end
	end

	assign hold_ms = (ctrl[1:0] == 2'h1) ? `PBC_MS_H01 :
		(ctrl[1:0] == 2'h2) ? `PBC_MS_H10 :
		(ctrl[1:0] == 2'h3) ? `PBC_MS_H11 : `PBC_MS_ON;

	// power state sequence
	always @*
	begin
		next_state    = state;
		next_armed    = armed | ~btn_low; // R10
		next_soft_rst = 1'b0;
		case (state)
			S_OFF:
				if (btn_low && !imp_low && armed &&
					press_ms >= `PBC_MS_ON)
					next_state = S_START; // R1
			S_START:
			begin
				if (fault_detected && btn_low)
				begin
					next_state = S_OFF; // R4
					next_armed = 1'b0;
				end
				else if (!btn_low)
					next_state = (all_in_regulation &&
						press_ms > hold_ms) ? S_ACT : S_OFF; // R2 R3 R5
			end
			S_ACT:
			begin
				next_soft_rst = btn_low & imp_low &
					(press_ms >= `PBC_MS_ON); // R11
				// R7 R12 R13
				if (release_ev && press_ms > `PBC_MS_CYCLE &&
					(imp_low || cycle_en))
					next_state = S_COFF; // R6
			end
			S_COFF:
				if (phase_ms >= `PBC_MS_STEP)
					next_state = S_CST; // R6
			S_CST:
				if (phase_ms >= `PBC_MS_STEP)
					next_state = S_ACT; // R6
			default:
				next_state = S_OFF;
		endcase
		// shutdown acts from any running state, without a release
		if ((state & (S_ACT | S_COFF | S_CST)) != 5'h00 &&
			btn_low && !imp_low && shut_en &&
			press_ms >= `PBC_MS_OFF)
		begin
			next_state    = S_OFF; // R8 R9 R13
			next_armed    = 1'b0; // R10
			next_soft_rst = 1'b0;
		end
	end

	always @(posedge clock)
	begin
		if (rst)
		begin
			state    <= S_OFF;
			armed    <= 1'b0;
			soft_rst <= 1'b0;
			// straps caught while reset is held; no write path exists
			cycle_en <= factory_config[0]; // R14
			shut_en  <= factory_config[1]; // R14
		end
		else if (clock_enable)
		begin
			state    <= next_state;
			armed    <= next_armed;
			soft_rst <= next_soft_rst;
		end
	end

	// multi-purpose pins
	genvar i;
	generate
		for (i = 0; i < 4; i = i + 1)
		begin : g_pin
			wire [2:0] fn = pincfg[i*`PBC_PIN_W+`PBC_PF_LSB +: 3];
			wire [1:0] md = pincfg[i*`PBC_PIN_W+`PBC_PM_LSB +: 2];
			wire       led_ok = (i >= `PBC_LED_FIRST); // R15 R16
			wire       is_in = (fn == `PBC_FN_EXT_GOOD) ||
				(fn == `PBC_FN_VSEL) || (md == `PBC_MODE_IN);
			// push-pull only on the lower pair, else open drain
			wire       pp = (md == `PBC_MODE_PP) && !led_ok; // R15 R16
			reg        val;
			always @*
			begin
				case (fn)
					`PBC_FN_RESET:  val = system_reset_n;
					`PBC_FN_IRQ:    val = interrupt_request_n;
					`PBC_FN_EXTERNAL_ENABLE_OUTPUT: val = regulator_enable;
					`PBC_FN_LED:    val = ~(led_ok & powered); // R16
					default:
						val = pincfg[i*`PBC_PIN_W+`PBC_PV_BIT];
				endcase
			end
			assign next_pin_out[i] = pp & val;
			assign next_pin_oe[i]  = ~is_in & (pp | ~val);
			assign good_hit[i] = (fn == `PBC_FN_EXT_GOOD) & pin_s[i];
			assign vsel_hit[i] = (fn == `PBC_FN_VSEL) & pin_s[i];
		end
	endgenerate

	always @(posedge clock)
	begin
		if (rst)
		begin
			regulator_enable       <= 1'b0;
			system_reset_n         <= 1'b0;
			interrupt_request_n    <= 1'b1;
			voltage_scaling_select <= 1'b0;
			external_good_input    <= 1'b0;
			multi_pin_out          <= 4'h0;
			multi_pin_oe           <= 4'h0;
		end
		else if (clock_enable)
		begin
			regulator_enable    <= powered; // R3 R10
			// processor held in reset unless active and no soft reset
			system_reset_n      <= (state == S_ACT) & ~soft_rst; // R11
			interrupt_request_n <= ~btn_low; // R17
			voltage_scaling_select <= |vsel_hit;
			external_good_input    <= |good_hit;
			multi_pin_out <= next_pin_out;
			multi_pin_oe  <= next_pin_oe;
		end
	end

	// register bus
	assign w_mask = {{8{w_strb[3]}}, {8{w_strb[2]}},
		{8{w_strb[1]}}, {8{w_strb[0]}}};

	always @*
	begin
		rd_hit  = 1'b1;
		rd_word = 32'h00000000;
		case (s_axi_araddr)
			`PBC_ADDR_CTRL:   rd_word = ctrl;
			`PBC_ADDR_PINCFG: rd_word = pincfg;
			`PBC_ADDR_STATUS:
				rd_word = {19'h00000, pin_s, shut_en, cycle_en,
					state, imp_low, btn_low}; // R17
			`PBC_ADDR_COUNT:  rd_word = {last_ms, press_ms}; // R17
			default:          rd_hit = 1'b0;
		endcase
	end

	always @(posedge clock)
	begin
		if (rst)
		begin
			s_axi_awready <= 1'b0;
			s_axi_wready  <= 1'b0;
			s_axi_bvalid  <= 1'b0;
			s_axi_bresp   <= `PBC_RESP_OKAY;
			s_axi_arready <= 1'b0;
			s_axi_rvalid  <= 1'b0;
			s_axi_rdata   <= 32'h00000000;
			s_axi_rresp   <= `PBC_RESP_OKAY;
			aw_full       <= 1'b0;
			w_full        <= 1'b0;
			aw_addr       <= 32'h00000000;
			w_data        <= 32'h00000000;
			w_strb        <= 4'h0;
			ctrl          <= `PBC_CTRL_RST;
			pincfg        <= `PBC_PINCFG_RST;
		end
		else if (clock_enable)
		begin
			if (s_axi_awready && s_axi_awvalid)
			begin
				aw_full       <= 1'b1;
				aw_addr       <= s_axi_awaddr;
				s_axi_awready <= 1'b0;
			end
			else if (!aw_full)
				s_axi_awready <= 1'b1;
			if (s_axi_wready && s_axi_wvalid)
			begin
				w_full       <= 1'b1;
				w_data       <= s_axi_wdata;
				w_strb       <= s_axi_wstrb;
				s_axi_wready <= 1'b0;
			end
			else if (!w_full)
				s_axi_wready <= 1'b1;
			if (aw_full && w_full && !s_axi_bvalid)
			begin
				aw_full      <= 1'b0;
				w_full       <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp  <= `PBC_RESP_OKAY;
				// status and count are read only; writes are dropped
				case (aw_addr)
					`PBC_ADDR_CTRL:
						ctrl <= {30'h00000000, ((ctrl[1:0] &
							~w_mask[1:0]) | (w_data[1:0] & w_mask[1:0]))};
					`PBC_ADDR_PINCFG:
						pincfg <= (pincfg & ~w_mask) | (w_data & w_mask);
					`PBC_ADDR_STATUS, `PBC_ADDR_COUNT:
						s_axi_bresp <= `PBC_RESP_OKAY;
					default:
						s_axi_bresp <= `PBC_RESP_SLVERR;
				endcase
			end
			else if (s_axi_bvalid && s_axi_bready)
				s_axi_bvalid <= 1'b0;
			if (s_axi_arready && s_axi_arvalid)
			begin
				s_axi_arready <= 1'b0;
				s_axi_rvalid  <= 1'b1;
				s_axi_rdata   <= rd_word;
				s_axi_rresp   <= rd_hit ? `PBC_RESP_OKAY :
					`PBC_RESP_SLVERR;
			end
			else if (s_axi_rvalid && s_axi_rready)
				s_axi_rvalid <= 1'b0;
			else if (!s_axi_rvalid)
				s_axi_arready <= 1'b1;
		end
	end
endmodule // pbc_top
`default_nettype wire

// file: verilog/pbc_consts.vh
`ifndef PBC_CONSTS_VH
`define PBC_CONSTS_VH
// timebase: one millisecond tick at an 8 ns clock
`define PBC_CLK_PERIOD_NS 8
`define PBC_TICK_NS       1000000
`define PBC_DIV_W         17
`define PBC_MS_W          16
`define PBC_MS_MAX        16'hFFFF
// press thresholds in ms (32 ms, 0.5 s, 1 s, 2 s, 4 s, 6 s)
`define PBC_MS_ON         16'h0020
`define PBC_MS_H01        16'h01F4
`define PBC_MS_H10        16'h03E8
`define PBC_MS_H11        16'h07D0
`define PBC_MS_CYCLE      16'h0FA0
`define PBC_MS_OFF        16'h1770
// power-cycle phase length, 0.5 s
`define PBC_MS_STEP       16'h01F4
// register byte addresses
`define PBC_ADDR_CTRL     32'h00000000
`define PBC_ADDR_PINCFG   32'h00000004
`define PBC_ADDR_STATUS   32'h00000008
`define PBC_ADDR_COUNT    32'h0000000C
`define PBC_RESP_OKAY     2'h0
`define PBC_RESP_SLVERR   2'h2
`define PBC_CTRL_RST      32'h00000000
`define PBC_PINCFG_RST    32'h0C0B0A09
// per-pin configuration byte
`define PBC_PIN_W         8
`define PBC_PF_LSB        0
`define PBC_PM_LSB        3
`define PBC_PV_BIT        5
`define PBC_FN_GPIO       3'h0
`define PBC_FN_RESET      3'h1
`define PBC_FN_IRQ        3'h2
`define PBC_FN_EXTERNAL_ENABLE_OUTPUT     3'h3
`define PBC_FN_LED        3'h4
`define PBC_FN_EXT_GOOD   3'h5
`define PBC_FN_VSEL       3'h6
`define PBC_MODE_IN       2'h0
`define PBC_MODE_OD       2'h1
`define PBC_MODE_PP       2'h2
`define PBC_LED_FIRST     2
`endif

// file: verilog/pbc_sync.v
`timescale 1ns/1ps
`default_nettype none
module pbc_sync #(
	parameter WIDTH = 1
) (
	// clocking
	input  wire             clock,
	input  wire             rst,
	input  wire             clock_enable,
	// asynchronous levels in, synchronised levels out
	input  wire [WIDTH-1:0] async_in,
	output reg  [WIDTH-1:0] sync_out
);
	reg [WIDTH-1:0] stage_one;
	// reset to ones: button and pins idle high
	always @(posedge clock)
	begin
		if (rst)
		begin
			stage_one <= {WIDTH{1'b1}};
			sync_out  <= {WIDTH{1'b1}};
		end
		else if (clock_enable)
		begin
			stage_one <= async_in;
			sync_out  <= stage_one;
		end
	end
endmodule // pbc_sync
`default_nettype wire

// file: verification/pbc_top_checker.sv
`timescale 1ns/1ps
`default_nettype none
module pbc_top_checker (
	// clocking
	input wire logic        clock,
	input wire logic        rst,
	// button and power
	input wire logic        button_press_n,
	input wire logic        interrupt_request_n,
	input wire logic        regulator_enable,
	input wire logic        system_reset_n,
	// pins
	input wire logic [3:0]  multi_pin_out,
	input wire logic [3:0]  multi_pin_oe,
	// bus
	input wire logic        s_axi_awvalid,
	input wire logic        s_axi_awready,
	input wire logic        s_axi_arvalid,
	input wire logic        s_axi_arready,
	input wire logic        s_axi_bvalid,
	input wire logic        s_axi_bready,
	input wire logic [1:0]  s_axi_bresp,
	input wire logic        s_axi_rvalid
);
	default clocking @(posedge clock); endclocking
	default disable iff (rst);
	irq_on_press_a: assert property (
		$fell(button_press_n) |-> ##3 !interrupt_request_n)
		else $error("interrupt missed a press");
	irq_on_release_a: assert property (
		$rose(button_press_n) |-> ##[1:3] interrupt_request_n)
		else $error("interrupt stuck after release");
	reset_while_off_a: assert property (
		!regulator_enable |-> !system_reset_n)
		else $error("processor released while outputs off");
	power_up_reset_a: assert property (
		$rose(regulator_enable) |-> !system_reset_n)
		else $error("outputs rose with processor running");
	upper_pins_od_a: assert property (
		(multi_pin_oe[3:2] & multi_pin_out[3:2]) == 2'h0)
		else $error("upper pin driven high");
	aw_pause_a: assert property (
		s_axi_awvalid && s_axi_awready |=> !s_axi_awready)
		else $error("second write address taken early");
	b_closes_a: assert property (
		s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
		else $error("write response repeated");
	read_answer_a: assert property (
		s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready)
		else $error("read answer late");
	cover property ($rose(regulator_enable));
	cover property ($fell(system_reset_n) && regulator_enable);
	cover property (s_axi_bvalid && s_axi_bresp == 2'h2);
endmodule // pbc_top_checker
bind pbc_top pbc_top_checker pbc_top_checker_inst (
	.clock, .rst, .button_press_n, .interrupt_request_n,
	.regulator_enable, .system_reset_n, .multi_pin_out, .multi_pin_oe,
	.s_axi_awvalid, .s_axi_awready, .s_axi_arvalid, .s_axi_arready,
	.s_axi_bvalid, .s_axi_bready, .s_axi_bresp, .s_axi_rvalid
);
`default_nettype wire

// file: verification/pbc_button_model.sv
`timescale 1ns/1ps
`default_nettype none
module pbc_button_model (
	// clocking
	input  wire logic clock,
	// switch contacts
	output var logic  button_press_n,
	output var logic  low_impedance
);
	logic held;
	initial
	begin
		held = 1'b0;
		button_press_n = 1'b1;
		low_impedance = 1'b0;
	end
	// path sense means nothing while open, so let it wander
	always @(posedge clock)
		if (!held)
			low_impedance <= ~low_impedance;
	// held is raised before the edge so the wander never races the press
	task automatic down(input logic low_path);
		held = 1'b1;
		@(posedge clock);
		low_impedance <= low_path;
		button_press_n <= 1'b0;
	endtask
	task automatic up();
		@(posedge clock);
		button_press_n <= 1'b1;
		held = 1'b0;
	endtask
endmodule // pbc_button_model
`default_nettype wire

// file: verification/tb.sv
`timescale 1ns/1ps
`default_nettype none
`include "pbc_consts.vh"
module tb;
	localparam int TICK = 2;
	logic        clock, rst, clock_enable, all_in_regulation, fault_detected;
	logic [1:0]  factory_config, s_axi_bresp, s_axi_rresp;
	logic        button_press_n, low_impedance, regulator_enable;
	logic        system_reset_n, interrupt_request_n;
	logic        voltage_scaling_select, external_good_input;
	logic [3:0]  multi_pin_in, multi_pin_out, multi_pin_oe, s_axi_wstrb;
	logic [31:0] s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_rdata;
	logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
	logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
	logic        s_axi_rvalid, s_axi_rready;
	logic [31:0] seed, d;
	int          mismatches, checks_done;
	logic [31:0] pin_cfg [4] = '{32'h30303030, 32'h10101010,
		32'h05050505, 32'h06060606};
	logic [9:0]  pin_exp [4] = '{10'h033, 10'h0F0, 10'h100, 10'h200};
	// pins carry pull-ups: an undriven pin reads high
	assign multi_pin_in = ~multi_pin_oe | multi_pin_out;
	pbc_top #(.TICK_CYCLES(TICK)) pbc_top_inst (.*);
	pbc_button_model btn (.clock, .button_press_n, .low_impedance);
	initial
	begin
		clock = 1'b0;
		forever #4 clock = ~clock;
	end
	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	function automatic int hold_ms(input logic [1:0] sel);
		return sel == 2'h0 ? 32 : sel == 2'h1 ? 500 : sel == 2'h2 ? 1000 : 2000;
	endfunction
	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		checks_done++;
		if (got !== exp)
		begin
			mismatches++;
			$display("BAD t=%0t seen=%h expected=%h", $time, got, exp);
		end
	endtask
	task automatic print_verdict();
		$display("checks %0d mismatches %0d", checks_done, mismatches);
		if (mismatches == 0 && checks_done > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	task automatic ms(input int n);
		repeat (n * TICK) @(posedge clock);
	endtask
	task automatic press(input logic low_path, input int n);
		btn.down(low_path);
		ms(n);
		btn.up();
	endtask
	task automatic do_reset(input logic [1:0] cfg);
		@(posedge clock);
		rst <= 1'b1;
		factory_config <= cfg;
		repeat (8) @(posedge clock);
		rst <= 1'b0;
		ms(4);
	endtask
	task automatic wr(input logic [31:0] a, v, input logic [1:0] er);
		@(posedge clock);
		s_axi_awaddr <= a;
		s_axi_wdata <= v;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		do
		begin
			@(posedge clock);
			if (s_axi_awready)
				s_axi_awvalid <= 1'b0;
			if (s_axi_wready)
				s_axi_wvalid <= 1'b0;
		end
		while (!s_axi_bvalid);
		s_axi_bready <= 1'b0;
		check(s_axi_bresp, er);
	endtask
	task automatic rd(input logic [31:0] a, output logic [31:0] v,
		input logic [1:0] er);
		@(posedge clock);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do
		begin
			@(posedge clock);
			if (s_axi_arready)
				s_axi_arvalid <= 1'b0;
		end
		while (!s_axi_rvalid);
		s_axi_rready <= 1'b0;
		v = s_axi_rdata;
		check(s_axi_rresp, er);
	endtask
	// after a long press ends: with yes, off, then start, then running; without, running throughout
	task automatic cycle_seen(input logic yes);
		ms(250);
		check(regulator_enable, !yes);
		ms(500);
		check({regulator_enable, system_reset_n}, {1'b1, !yes});
		ms(400);
		check({regulator_enable, system_reset_n}, 2'h3);
	endtask
	initial
	begin
		repeat (90000) @(posedge clock);
		mismatches++;
		print_verdict();
	end
	initial
	begin
		{rst, clock_enable, all_in_regulation, fault_detected} = 4'hE;
		factory_config = 2'h0;
		{s_axi_awaddr, s_axi_wdata, s_axi_araddr} = 96'h0;
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 3'h0;
		{s_axi_arvalid, s_axi_rready} = 2'h0;
		s_axi_wstrb = 4'hF;
		seed = 32'h8EE4;
		do_reset(2'h0);
		rd(`PBC_ADDR_PINCFG, d, `PBC_RESP_OKAY);
		check(d, `PBC_PINCFG_RST);
		rd(32'h00000010, d, `PBC_RESP_SLVERR);
		check(d, 32'h0);
		wr(32'h00000010, 32'hFFFFFFFF, `PBC_RESP_SLVERR);
		foreach (pin_cfg[i])
		begin
			wr(`PBC_ADDR_PINCFG, pin_cfg[i], `PBC_RESP_OKAY);
			repeat (6) @(posedge clock);
			d = {22'h0, voltage_scaling_select, external_good_input,
				multi_pin_oe, multi_pin_out};
			check(d, {22'h0, pin_exp[i]});
		end
		// short press, unregulated outputs, fault while held
		wr(`PBC_ADDR_CTRL, 32'h1, `PBC_RESP_OKAY);
		for (int i = 0; i < 3; i++)
		begin
			btn.down(1'b0);
			ms(40);
			check(regulator_enable, 1'b1);
			all_in_regulation <= (i != 1);
			fault_detected <= (i == 2);
			ms(i == 0 ? 200 : 560);
			btn.up();
			ms(10);
			check(regulator_enable, 1'b0);
			all_in_regulation <= 1'b1;
			fault_detected <= 1'b0;
			ms(5);
		end
		seed = lfsr(seed);
		wr(`PBC_ADDR_CTRL, seed, `PBC_RESP_OKAY);
		rd(`PBC_ADDR_CTRL, d, `PBC_RESP_OKAY);
		check(d, {30'h0, seed[1:0]});
		btn.down(1'b0);
		ms(hold_ms(seed[1:0]) + 60);
		check(system_reset_n, 1'b0);
		btn.up();
		ms(10);
		check({regulator_enable, system_reset_n}, 2'h3);
		for (int i = 0; i < 2; i++)
		begin
			seed = lfsr(seed);
			btn.down(1'b1);
			ms(20);
			check(system_reset_n, 1'b1);
			ms(16);
			check({regulator_enable, system_reset_n}, 2'h2);
			rd(`PBC_ADDR_STATUS, d, `PBC_RESP_OKAY);
			check(d[1:0], 2'h3);
			check(interrupt_request_n, 1'b0);
			rd(`PBC_ADDR_COUNT, d, `PBC_RESP_OKAY);
			check((d[15:0] > 16'h0021) && (d[15:0] < 16'h002A), 1'b1);
			ms(seed[7:0]);
			btn.up();
			ms(4);
			check({regulator_enable, system_reset_n}, 2'h3);
		end
		press(1'b1, 4100);
		cycle_seen(1'b1);
		press(1'b0, 4100);
		cycle_seen(1'b0);
		press(1'b0, 6100);
		cycle_seen(1'b0);
		// both straps set; reset mid-run to take them
		do_reset(2'h3);
		wr(`PBC_ADDR_STATUS, 32'h0, `PBC_RESP_OKAY);
		rd(`PBC_ADDR_STATUS, d, `PBC_RESP_OKAY);
		check(d[8:7], 2'h3);
		press(1'b0, 100);
		ms(10);
		check({regulator_enable, system_reset_n}, 2'h3);
		// reset pin map: reset, interrupt, enable, led, all open drain
		check({multi_pin_oe, multi_pin_out}, 8'h80);
		press(1'b0, 4100);
		cycle_seen(1'b1);
		btn.down(1'b0);
		ms(6050);
		check(regulator_enable, 1'b0);
		btn.up();
		ms(600);
		check(regulator_enable, 1'b0);
		check({multi_pin_oe, multi_pin_out}, 8'h50);
		print_verdict();
	end
endmodule // tb
`default_nettype wire
